// [rtl/phc_pkg.sv]
/*
  Shared constants, field positions and carrier types for the upper part of
  the configuration header. Assumes a single 250 MHz system clock.
*/
`default_nettype none

package phc_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int HOLD_UNIT_CLKS = 8;                    // one timer unit
  localparam int EE_BIT_NS      = 1000;                 // serial bit period
  localparam int EE_HALF_CLKS   = (EE_BIT_NS / 2) / CLK_PERIOD_NS;
  localparam int EE_LOAD_BITS   = 72;                   // bits in the image

  // ----------------------------------------------------------------------
  // configuration byte offsets (dword aligned)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_WORD = 8'h0C;
  localparam logic [7:0] OFS_MEM_BASE   = 8'h10;
  localparam logic [7:0] OFS_CARD_INFO  = 8'h28;
  localparam logic [7:0] OFS_BOARD_ID   = 8'h2C;
  localparam logic [7:0] OFS_ROM_BASE   = 8'h30;
  localparam logic [7:0] OFS_CAP_HEAD   = 8'h34;
  localparam logic [7:0] OFS_IRQ_WORD   = 8'h3C;
  localparam logic [7:0] OFS_SWAP_CTRL  = 8'h40;

  // ----------------------------------------------------------------------
  // field positions and fixed or reset values
  // ----------------------------------------------------------------------
  localparam int          MEM_BASE_LSB    = 11;
  localparam int          ROM_BASE_LSB    = 16;
  localparam logic [7:0]  TIMER_RST       = 8'h00;
  localparam logic [7:0]  LAYOUT_CODE     = 8'h00;
  localparam logic [7:0]  SELF_TEST_VAL   = 8'h00;
  localparam logic [7:0]  IRQ_ROUTING_RST = 8'h00;
  localparam logic [7:0]  IRQ_PIN_VAL     = 8'h01;
  localparam logic [7:0]  MIN_GRANT_VAL   = 8'h20;
  localparam logic [7:0]  MAX_LAT_VAL     = 8'h50;
  localparam logic [20:0] MEM_BASE_RST    = 21'h000000;
  localparam logic [15:0] ROM_BASE_RST    = 16'h0000;
  localparam logic [31:0] HC_WIN_BYTES    = 32'h00001000;  // 4096
  localparam logic [31:0] DBG_WIN_BYTES   = 32'h00000800;  // 2048

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } phc_cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } phc_cfg_rsp_t;

  typedef struct packed {
    logic [31:0] card_info_offset;
    logic [15:0] board_product_code;
    logic [15:0] board_maker_code;
    logic [7:0]  cap_head;
  } phc_ee_image_t;

  typedef struct packed {
    logic hc_hit;
    logic dbg_hit;
    logic rom_hit;
  } phc_decode_t;

endpackage : phc_pkg

`default_nettype wire

// [rtl/phc_ee_loader.sv]
/*
  Serial EEPROM image loader: after reset release it clocks in the image
  once, MSB first, and holds it. Assumes the EEPROM drives its data bit
  before each rising edge of the serial clock while select is high.
*/
`timescale 1ns/1ps
`default_nettype none

module phc_ee_loader #(
  parameter int HALF_CLKS = phc_pkg::EE_HALF_CLKS,
  parameter int NBITS     = phc_pkg::EE_LOAD_BITS
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   ee_di,
  output var  logic                   ee_clk,
  output var  logic                   ee_cs,
  output var  logic                   load_done,
  output var  phc_pkg::phc_ee_image_t image
);
  import phc_pkg::*;

  if (HALF_CLKS < 1 || NBITS != $bits(phc_ee_image_t)) begin : g_chk
    $error("phc_ee_loader: bad parameters");
  end

  typedef enum logic [1:0] {PHC_EE_IDLE = 2'b00, PHC_EE_SHIFT = 2'b01,
                            PHC_EE_DONE = 2'b11} phc_ee_state_t;

  phc_ee_state_t            state;
  logic [$clog2(HALF_CLKS+1)-1:0] half_cnt;
  logic [$clog2(NBITS+1)-1:0]     bit_cnt;
  logic [NBITS-1:0]         shreg;
  logic                     half_tick;

  assign half_tick = (half_cnt == ($clog2(HALF_CLKS+1))'(HALF_CLKS - 1));

  // sequencer: one pass after reset, then idle for good
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state     <= PHC_EE_IDLE;
      half_cnt  <= '0;
      bit_cnt   <= '0;
      shreg     <= '0;
      ee_clk    <= 1'b0;
      ee_cs     <= 1'b0;
      load_done <= 1'b0;
      image     <= '0;
    end else begin
      case (state)
        PHC_EE_IDLE: begin
          ee_cs <= 1'b1;
          state <= PHC_EE_SHIFT;
        end
        PHC_EE_SHIFT: begin
          half_cnt <= half_tick ? '0 : half_cnt + 1'b1;
          if (half_tick) begin
            ee_clk <= ~ee_clk;
            if (!ee_clk) begin                         // rising edge: sample
              shreg   <= {shreg[NBITS-2:0], ee_di};
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt == ($clog2(NBITS+1))'(NBITS - 1)) begin
                image     <= {shreg[NBITS-2:0], ee_di};
                load_done <= 1'b1;
                ee_cs     <= 1'b0;
                ee_clk    <= 1'b0;
                state     <= PHC_EE_DONE;
              end
            end
          end
        end
        PHC_EE_DONE: state <= PHC_EE_DONE;
        default:     state <= PHC_EE_IDLE;
      endcase
    end
  end

  a_ee_bus_idle: assert property (@(posedge sys_clk) disable iff (rst)
    load_done |-> (!ee_cs && !ee_clk && state == PHC_EE_DONE))
    else $error("serial port active after load");

endmodule : phc_ee_loader

`default_nettype wire

// [rtl/phc_hold_timer.sv]
/*
  Bus-hold timer: counts initiator bus tenure in units of eight clocks from
  the frame start and flags when the programmed limit is reached. Assumes
  start is a one-cycle pulse at the first frame assertion as initiator.
*/
`timescale 1ns/1ps
`default_nettype none

module phc_hold_timer #(
  parameter int UNIT_CLKS = phc_pkg::HOLD_UNIT_CLKS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       holding,
  input  wire logic [7:0] limit,
  output var  logic       expired
);
  import phc_pkg::*;

  if (UNIT_CLKS < 2 || (UNIT_CLKS & (UNIT_CLKS - 1)) != 0) begin : g_chk
    $error("phc_hold_timer: unit must be a power of two");
  end

  localparam int DW = $clog2(UNIT_CLKS);

  logic [DW-1:0] div;
  logic [7:0]    units;

  // tenure counter, restarted on every frame start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div   <= '0;
      units <= '0;
    end else if (start) begin
      div   <= '0;
      units <= '0;
    end else if (holding) begin
      div <= div + 1'b1;
      if (&div && units != 8'hFF) begin
        units <= units + 8'h01;
      end
    end
  end

  // expiry flag against the programmed limit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      expired <= 1'b0;
    end else begin
      expired <= holding && !start && (units >= limit);
    end
  end

  a_hold_unit_step: assert property (@(posedge sys_clk) disable iff (rst)
    (holding && !start && &div && units != 8'hFF) |=> units == $past(units) + 8'h01)
    else $error("timer unit not eight clocks");
  a_hold_expiry: assert property (@(posedge sys_clk) disable iff (rst)
    (holding && !start && units >= limit) |=> expired)
    else $error("tenure limit missed");

endmodule : phc_hold_timer

`default_nettype wire

// [rtl/phc_cfg_upper.sv]
/*
  Upper configuration header: bus-hold timer, layout and self-test bytes,
  register-window base and decode, EEPROM-loaded identity words, boot-ROM
  base and decode, interrupt bytes, grant and latency figures, byte swap.
  Assumes configuration requests come one per cycle at most from the PCI
  target front end, and the command register memory enable is supplied.
*/
`timescale 1ns/1ps
`default_nettype none

module phc_cfg_upper (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire phc_pkg::phc_cfg_req_t cfg_in,
  output var  phc_pkg::phc_cfg_rsp_t cfg_out,
  input  wire logic                  cmd_mem_enable,
  input  wire logic                  debug_enable,
  input  wire logic                  mem_valid,
  input  wire logic [31:0]           mem_addr,
  output var  phc_pkg::phc_decode_t  decode,
  input  wire logic                  init_frame_start,
  input  wire logic                  init_holding,
  output var  logic                  hold_expired,
  input  wire logic [31:0]           pci_rx_data,
  output var  logic [31:0]           core_rx_data,
  input  wire logic [31:0]           core_tx_data,
  output var  logic [31:0]           pci_tx_data,
  input  wire logic                  ee_di,
  output var  logic                  ee_clk,
  output var  logic                  ee_cs,
  output var  logic                  ee_load_done
);
  import phc_pkg::*;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0]    bus_hold_timer;
  logic [20:0]   mem_base;           // bits 31:11 of the window base
  logic [15:0]   rom_base;
  logic          rom_enable;
  logic [7:0]    irq_routing;
  logic          global_swap;
  phc_ee_image_t ee_image;
  logic [31:0]   next_rdata;
  logic          cfg_wr;
  logic [31:0]   eff_base;
  logic [31:0]   win_off;
  logic          rd_q;
  logic [7:0]    rd_addr_q;

  assign cfg_wr = cfg_in.req && cfg_in.we;

  // byte order reversal within a dword
  function automatic logic [31:0] bswap(input logic [31:0] d);
    bswap = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // ----------------------------------------------------------------------
  // loader and tenure timer
  // ----------------------------------------------------------------------
  // identity words come from the serial EEPROM after reset release
  phc_ee_loader #(
    .HALF_CLKS (EE_HALF_CLKS),
    .NBITS     (EE_LOAD_BITS)
  ) u_loader (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ee_di     (ee_di),
    .ee_clk    (ee_clk),
    .ee_cs     (ee_cs),
    .load_done (ee_load_done),
    .image     (ee_image)
  );

  // bus tenure against the programmed limit
  phc_hold_timer #(
    .UNIT_CLKS (HOLD_UNIT_CLKS)
  ) u_hold (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .start     (init_frame_start),
    .holding   (init_holding),
    .limit     (bus_hold_timer),
    .expired   (hold_expired)
  );

  // ----------------------------------------------------------------------
  // writable fields
  // ----------------------------------------------------------------------
  // bus-hold timer byte, lane 1 of the 0Ch word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_hold_timer <= TIMER_RST;
    end else if (cfg_wr && cfg_in.addr == OFS_TIMER_WORD && cfg_in.be[1]) begin
      bus_hold_timer <= cfg_in.wdata[15:8];
    end
  end

  // window base: bit 11 frozen while debug registers are on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_base <= MEM_BASE_RST;
    end else if (cfg_wr && cfg_in.addr == OFS_MEM_BASE) begin
      if (cfg_in.be[1]) begin
        mem_base[4:1] <= cfg_in.wdata[15:12];
        if (!debug_enable) begin
          mem_base[0] <= cfg_in.wdata[MEM_BASE_LSB];
        end
      end
      if (cfg_in.be[2]) begin
        mem_base[12:5] <= cfg_in.wdata[23:16];
      end
      if (cfg_in.be[3]) begin
        mem_base[20:13] <= cfg_in.wdata[31:24];
      end
    end
  end

  // boot-ROM base and enable; bits 15:1 have no storage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rom_base   <= ROM_BASE_RST;
      rom_enable <= 1'b0;
    end else if (cfg_wr && cfg_in.addr == OFS_ROM_BASE) begin
      if (cfg_in.be[0]) begin
        rom_enable <= cfg_in.wdata[0];
      end
      if (cfg_in.be[2]) begin
        rom_base[7:0] <= cfg_in.wdata[23:16];
      end
      if (cfg_in.be[3]) begin
        rom_base[15:8] <= cfg_in.wdata[31:24];
      end
    end
  end

  // interrupt routing byte, plain storage for software
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_routing <= IRQ_ROUTING_RST;
    end else if (cfg_wr && cfg_in.addr == OFS_IRQ_WORD && cfg_in.be[0]) begin
      irq_routing <= cfg_in.wdata[7:0];
    end
  end

  // global byte-swap control
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      global_swap <= 1'b0;
    end else if (cfg_wr && cfg_in.addr == OFS_SWAP_CTRL && cfg_in.be[0]) begin
      global_swap <= cfg_in.wdata[0];
    end
  end

  // ----------------------------------------------------------------------
  // configuration read path
  // ----------------------------------------------------------------------
  // read mux; fixed and loaded fields have no write path at all
  always_comb begin
    next_rdata = 32'h00000000;                         // unmapped reads zero
    case (cfg_in.addr)
      OFS_TIMER_WORD: next_rdata = {SELF_TEST_VAL, LAYOUT_CODE,
                                    bus_hold_timer, 8'h00};
      OFS_MEM_BASE:   next_rdata = {mem_base[20:1],
                                    debug_enable ? 1'b0 : mem_base[0],
                                    11'h000};
      OFS_CARD_INFO:  next_rdata = ee_image.card_info_offset;
      OFS_BOARD_ID:   next_rdata = {ee_image.board_product_code,
                                    ee_image.board_maker_code};
      OFS_ROM_BASE:   next_rdata = {rom_base, 15'h0000, rom_enable};
      OFS_CAP_HEAD:   next_rdata = {24'h000000, ee_image.cap_head};
      OFS_IRQ_WORD:   next_rdata = {MAX_LAT_VAL, MIN_GRANT_VAL,
                                    IRQ_PIN_VAL, irq_routing};
      OFS_SWAP_CTRL:  next_rdata = {31'h00000000, global_swap};
      default:        next_rdata = 32'h00000000;
    endcase
  end

  // answer one cycle after each request; writes return zero data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_out   <= '0;
      rd_q      <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      cfg_out.ack   <= cfg_in.req;
      cfg_out.rdata <= (cfg_in.req && !cfg_in.we) ? next_rdata : 32'h00000000;
      rd_q          <= cfg_in.req && !cfg_in.we;
      rd_addr_q     <= cfg_in.addr;
    end
  end

  // ----------------------------------------------------------------------
  // memory decode
  // ----------------------------------------------------------------------
  // with debug on, bit 11 of the base is forced low: 4K alignment
  assign eff_base = {mem_base[20:1], mem_base[0] && !debug_enable, 11'h000};
  assign win_off  = mem_addr - eff_base;

  // registered hit flags, all gated by the memory enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      decode <= '0;
    end else begin
      decode.hc_hit  <= mem_valid && cmd_mem_enable
                        && (win_off < HC_WIN_BYTES);
      decode.dbg_hit <= mem_valid && cmd_mem_enable && debug_enable
                        && (win_off >= HC_WIN_BYTES)
                        && (win_off < (HC_WIN_BYTES + DBG_WIN_BYTES));
      decode.rom_hit <= mem_valid && cmd_mem_enable && rom_enable
                        && (mem_addr[31:ROM_BASE_LSB] == rom_base);
    end
  end

  // ----------------------------------------------------------------------
  // data swap
  // ----------------------------------------------------------------------
  // both directions pass one register, reversed when swap is set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_rx_data <= 32'h00000000;
      pci_tx_data  <= 32'h00000000;
    end else begin
      core_rx_data <= global_swap ? bswap(pci_rx_data) : pci_rx_data;
      pci_tx_data  <= global_swap ? bswap(core_tx_data) : core_tx_data;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // 0Ch word: fixed bytes and timer storage
  a_layout_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_q && rd_addr_q == OFS_TIMER_WORD) |-> cfg_out.rdata[23:16] == 8'h00)
    else $error("layout code not zero");
  a_self_test_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_q && rd_addr_q == OFS_TIMER_WORD) |-> cfg_out.rdata[31:24] == 8'h00)
    else $error("self-test byte not zero");
  a_timer_write: assert property (@(posedge sys_clk) disable iff (rst)
    (cfg_wr && cfg_in.addr == OFS_TIMER_WORD && cfg_in.be[1])
      |=> bus_hold_timer == $past(cfg_in.wdata[15:8]))
    else $error("timer byte not stored");

  // window base: hidden bit, low bits, bit 11 frozen with debug on
  a_base_bit_hidden: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_q && rd_addr_q == OFS_MEM_BASE && $past(debug_enable))
      |-> !cfg_out.rdata[11])
    else $error("base bit 11 visible with debug on");
  a_base_low_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_q && rd_addr_q == OFS_MEM_BASE) |-> cfg_out.rdata[10:0] == 11'h000)
    else $error("base low bits not zero");
  a_base_bit_kept: assert property (@(posedge sys_clk) disable iff (rst)
    (cfg_wr && cfg_in.addr == OFS_MEM_BASE && cfg_in.be[1] && debug_enable)
      |=> mem_base[0] == $past(mem_base[0]))
    else $error("base bit 11 written with debug on");

  // boot-ROM and capability words
  a_rom_low_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_q && rd_addr_q == OFS_ROM_BASE) |-> cfg_out.rdata[15:1] == 15'h0000)
    else $error("boot-ROM base low bits not zero");
  a_cap_upper_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_q && rd_addr_q == OFS_CAP_HEAD) |-> cfg_out.rdata[31:8] == 24'h000000)
    else $error("capability word upper bits not zero");

  // interrupt word and loaded words
  a_fixed_irq_bytes: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_q && rd_addr_q == OFS_IRQ_WORD)
      |-> cfg_out.rdata[31:8] == {MAX_LAT_VAL, MIN_GRANT_VAL, IRQ_PIN_VAL})
    else $error("pin, grant or latency byte wrong");
  a_routing_write: assert property (@(posedge sys_clk) disable iff (rst)
    (cfg_wr && cfg_in.addr == OFS_IRQ_WORD && cfg_in.be[0])
      |=> irq_routing == $past(cfg_in.wdata[7:0]))
    else $error("routing byte not stored");
  a_ro_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    (ee_load_done && cfg_wr && cfg_in.addr == OFS_CARD_INFO)
      |=> $stable(ee_image))
    else $error("read-only word changed by write");

  // memory decode: gating and windows
  a_mem_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (decode.hc_hit || decode.dbg_hit || decode.rom_hit)
      |-> $past(cmd_mem_enable) && $past(mem_valid))
    else $error("decode without memory enable");
  a_hc_decode: assert property (@(posedge sys_clk) disable iff (rst)
    (mem_valid && cmd_mem_enable && win_off < HC_WIN_BYTES) |=> decode.hc_hit)
    else $error("host window missed");
  a_dbg_decode: assert property (@(posedge sys_clk) disable iff (rst)
    (mem_valid && cmd_mem_enable && debug_enable && win_off >= HC_WIN_BYTES
      && win_off < HC_WIN_BYTES + DBG_WIN_BYTES) |=> decode.dbg_hit)
    else $error("debug window missed");
  a_dbg_window: assert property (@(posedge sys_clk) disable iff (rst)
    decode.dbg_hit |-> ($past(debug_enable) && !decode.hc_hit))
    else $error("debug decode while disabled");
  a_rom_gate: assert property (@(posedge sys_clk) disable iff (rst)
    decode.rom_hit |-> $past(rom_enable))
    else $error("rom decode while disabled");
  a_rom_decode: assert property (@(posedge sys_clk) disable iff (rst)
    (mem_valid && cmd_mem_enable && rom_enable && mem_addr[31:ROM_BASE_LSB] == rom_base)
      |=> decode.rom_hit)
    else $error("boot-ROM window missed");

  // data swap in both directions
  a_swap_path: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 pci_tx_data == ($past(global_swap) ? bswap($past(core_tx_data))
                                           : $past(core_tx_data)))
    else $error("transmit swap wrong");
  a_swap_rx: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 core_rx_data == ($past(global_swap) ? bswap($past(pci_rx_data))
                                            : $past(pci_rx_data)))
    else $error("receive swap wrong");

  // main scenarios reached
  c_dbg_hit:   cover property (@(posedge sys_clk) disable iff (rst) decode.dbg_hit);
  c_rom_hit:   cover property (@(posedge sys_clk) disable iff (rst) decode.rom_hit);
  c_load_done: cover property (@(posedge sys_clk) disable iff (rst) $rose(ee_load_done));
  c_expired:   cover property (@(posedge sys_clk) disable iff (rst) $rose(hold_expired));
  c_swap_on:   cover property (@(posedge sys_clk) disable iff (rst) $rose(global_swap));

endmodule : phc_cfg_upper

`default_nettype wire

// [test/phc_ee_model.sv]
/* serial EEPROM model: shifts a fixed image out MSB first.
   Assumes the loader samples data on rising serial clock edges. */
`timescale 1ns/1ps
`default_nettype none
module phc_ee_model #(
  parameter logic [71:0] IMAGE = 72'h0
) (
  input  wire logic ee_clk,
  input  wire logic ee_cs,
  output var  logic ee_di
);
  logic [6:0] idx = 7'h47;
  // step to the next bit after each falling serial clock
  always @(negedge ee_clk) begin
    if (ee_cs && idx != 7'h0) idx <= idx - 7'h1;
  end
  // deselected: drive the inverse so stale data never looks valid
  assign ee_di = ee_cs ? IMAGE[idx] : ~IMAGE[idx];
endmodule // phc_ee_model
`default_nettype wire

// [test/pci_config_header_upper_tb.sv]
/* bench for the upper configuration header: config, decode, timer, swap.
   Assumes the EEPROM model on the serial pins and default loader timing. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module pci_config_header_upper_tb;
  import phc_pkg::*;
  localparam logic [71:0] IMG = 72'h1234_5678_ABCD_5A5A_44;  // arbitrary image
  logic sys_clk = 1'b0, rst = 1'b1, cmd_mem_enable = 1'b1, debug_enable = 1'b0;
  logic mem_valid = 1'b0, init_frame_start = 1'b0, init_holding = 1'b0;
  logic [31:0] mem_addr = 32'h0, pci_rx_data = 32'h0, core_tx_data = 32'h0;
  logic [31:0] core_rx_data, pci_tx_data;
  logic hold_expired, ee_di, ee_clk, ee_cs, ee_load_done;
  phc_cfg_req_t cfg_in = '0;
  phc_cfg_rsp_t cfg_out;
  phc_decode_t decode;
  int fail_count = 0, total_checks = 0, cycles = 0;
  phc_cfg_upper dut (.sys_clk, .rst, .cfg_in, .cfg_out, .cmd_mem_enable, .debug_enable,
    .mem_valid, .mem_addr, .decode, .init_frame_start, .init_holding, .hold_expired,
    .pci_rx_data, .core_rx_data, .core_tx_data, .pci_tx_data, .ee_di, .ee_clk, .ee_cs,
    .ee_load_done);
  phc_ee_model #(.IMAGE(IMG)) u_ee (.ee_clk(ee_clk), .ee_cs(ee_cs), .ee_di(ee_di));
  always #2 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic cfg(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n = 0;
    @(negedge sys_clk) cfg_in = '{1'b1, we, a, be, d};
    @(negedge sys_clk) cfg_in.req = 1'b0;
    while (cfg_out.ack !== 1'b1 && n < 3) begin @(negedge sys_clk); n++; end
    `CHK(cfg_out.ack, 1'b1)
    q = cfg_out.rdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    cfg(1'b0, a, 32'h0, 4'h0, q);
    `CHK(q, e)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    cfg(1'b1, a, d, 4'hF, q);
  endtask
  task automatic dec(input logic [31:0] a, input phc_decode_t e);
    @(negedge sys_clk) begin mem_valid = 1'b1; mem_addr = a; end
    @(negedge sys_clk) mem_valid = 1'b0;
    `CHK(decode, e)
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_TIMER_WORD, 32'h0);
    rd(OFS_IRQ_WORD, 32'h5020_0100);
    rd(OFS_SWAP_CTRL, 32'h0);
    wr(OFS_TIMER_WORD, 32'hFFFF_FFFF); rd(OFS_TIMER_WORD, 32'h0000_FF00);
    wr(OFS_IRQ_WORD, 32'hFFFF_FFFF); rd(OFS_IRQ_WORD, 32'h5020_01FF);
    wr(OFS_IRQ_WORD, 32'h0F); rd(OFS_IRQ_WORD, 32'h5020_010F);
  endtask
  task automatic t_base;
    rd(OFS_MEM_BASE, 32'h0);
    wr(OFS_MEM_BASE, 32'hFFFF_FFFF); rd(OFS_MEM_BASE, 32'hFFFF_F800);
    debug_enable = 1'b1; rd(OFS_MEM_BASE, 32'hFFFF_F000);
    debug_enable = 1'b0; wr(OFS_MEM_BASE, 32'h4000_0800);
    dec(32'h4000_0800, 3'h4); dec(32'h4000_17FC, 3'h4);
    dec(32'h4000_1800, 3'h0); dec(32'h4000_07FC, 3'h0);
    debug_enable = 1'b1;
    dec(32'h4000_0FFC, 3'h4); dec(32'h4000_1000, 3'h2);
    dec(32'h4000_17FC, 3'h2); dec(32'h4000_1800, 3'h0);
    wr(OFS_MEM_BASE, 32'h5000_0000); debug_enable = 1'b0;
    rd(OFS_MEM_BASE, 32'h5000_0800);
    cmd_mem_enable = 1'b0; dec(32'h5000_0800, 3'h0);
    cmd_mem_enable = 1'b1;
  endtask
  task automatic t_rom;
    rd(OFS_ROM_BASE, 32'h0);
    wr(OFS_ROM_BASE, 32'hFFFF_FFFF); rd(OFS_ROM_BASE, 32'hFFFF_0001);
    wr(OFS_ROM_BASE, 32'h1234_0001); dec(32'h1234_ABCC, 3'h1);
    dec(32'h1235_0000, 3'h0);
    cmd_mem_enable = 1'b0; dec(32'h1234_ABCC, 3'h0);
    cmd_mem_enable = 1'b1; wr(OFS_ROM_BASE, 32'h1234_0000); dec(32'h1234_ABCC, 3'h0);
  endtask
  task automatic t_swap;
    wr(OFS_SWAP_CTRL, 32'hFFFF_FFFF); rd(OFS_SWAP_CTRL, 32'h1);
    pci_rx_data = 32'h1122_3344; core_tx_data = 32'hA1B2_C3D4;
    @(negedge sys_clk); `CHK(core_rx_data, 32'h4433_2211)
    `CHK(pci_tx_data, 32'hD4C3_B2A1)
    wr(OFS_SWAP_CTRL, 32'h0);
    @(negedge sys_clk);
    `CHK(core_rx_data, 32'h1122_3344)
    `CHK(pci_tx_data, 32'hA1B2_C3D4)
  endtask
  task automatic t_timer;
    logic [31:0] q;
    int n = 0;
    cfg(1'b1, OFS_TIMER_WORD, 32'h0000_0200, 4'h2, q); rd(OFS_TIMER_WORD, 32'h200);
    @(negedge sys_clk) begin init_frame_start = 1'b1; init_holding = 1'b1; end
    @(negedge sys_clk) init_frame_start = 1'b0;
    while (hold_expired !== 1'b1 && n < 40) begin @(negedge sys_clk); n++; end
    `CHK(n, 2 * HOLD_UNIT_CLKS + 1)
    init_holding = 1'b0; repeat (2) @(negedge sys_clk);
    `CHK(hold_expired, 1'b0)
  endtask
  task automatic t_eeprom;
    int n = 0;
    while (ee_load_done !== 1'b1 && n < 30000) begin @(negedge sys_clk); n++; end
    `CHK(ee_load_done, 1'b1)
    `CHK({ee_cs, ee_clk}, 2'b00)
    rd(OFS_CARD_INFO, IMG[71:40]); rd(OFS_BOARD_ID, IMG[39:8]);
    rd(OFS_CAP_HEAD, {24'h0, IMG[7:0]});
    wr(OFS_CARD_INFO, 32'h0); wr(OFS_BOARD_ID, 32'h0); wr(OFS_CAP_HEAD, 32'h0);
    rd(OFS_CARD_INFO, IMG[71:40]); rd(OFS_BOARD_ID, IMG[39:8]);
    rd(OFS_CAP_HEAD, {24'h0, IMG[7:0]});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, well above the serial load time
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin fail_count++; results; end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    t_reset; t_base; t_rom; t_swap; t_timer; t_eeprom;
    results;
  end
endmodule // pci_config_header_upper_tb
`default_nettype wire
